// ### design/dfs_params.svh
/*
 Constants of the data-flash command sequencer: codes, indices, address
 layout and timing counts. Included by the package and the design modules.
*/
`ifndef DFS_PARAMS_SVH
`define DFS_PARAMS_SVH
`define DFS_CMD_PROGRAM 8'h11
`define DFS_CMD_ERASE 8'h12
`define DFS_IDX_CMD 3'h0
`define DFS_IDX_ADDR 3'h1
`define DFS_IDX_WORD0 3'h2
`define DFS_IDX_WORD3 3'h5
`define DFS_SEC_ADDR 23'h7fff0f
`define DFS_BLK_HI 7'h10
`define DFS_BLK_BASE 16'h0000
`define DFS_BLK_LAST 16'h1fff
`define DFS_SECT_BITS 8
`define DFS_RESET_SEQ_CYC 8'h10
`define DFS_PROG_CYC 8'h20
`define DFS_ERASE_CYC 8'h40
`define DFS_SEC_DEFAULT 8'hff
`endif

// ### design/dfs_pkg.sv
/*
 Types of the data-flash command sequencer.
 Assumes dfs_params.svh is on the include path.
*/
`include "dfs_params.svh"
package dfs_pkg;
  typedef enum logic [2:0] {
    DFS_RST_SEQ = 3'b000,
    DFS_IDLE = 3'b001,
    DFS_CHECK = 3'b011,
    DFS_WORK = 3'b010,
    DFS_VERIFY = 3'b110
  } dfs_state_e;

  typedef struct packed {
    logic access_error_flag;
    logic protection_violation_flag;
    logic verify_any_error_flag;
    logic verify_uncorrectable_flag;
  } dfs_err_s;

  typedef struct packed {
    logic req;
    logic erase;
    logic [22:0] addr;
    logic [15:0] data;
  } dfs_mem_s;
endpackage : dfs_pkg

// ### design/dfs_irq.sv
/*
 Interrupt request builder of the data-flash command sequencer.
 Assumes flags and enables come from the same clock domain.
*/
`timescale 1ns/100ps
`include "dfs_params.svh"
module dfs_irq (
  input wire logic clk,
  input wire logic reset,
  input wire logic command_complete_flag,
  input wire logic command_complete_irq_enable,
  input wire logic double_fault_flag,
  input wire logic double_fault_irq_enable,
  input wire logic single_fault_flag,
  input wire logic single_fault_irq_enable,
  output logic cmd_irq,
  output logic err_irq
);
  logic cmd_d;
  logic err_d;

  always_comb begin
    cmd_d = command_complete_flag & command_complete_irq_enable;
    err_d = (double_fault_flag & double_fault_irq_enable) | (single_fault_flag & single_fault_irq_enable);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_irq <= 1'b0;
      err_irq <= 1'b0;
    end else begin
      cmd_irq <= cmd_d;
      err_irq <= err_d;
    end
  end
endmodule : dfs_irq

// ### design/dfs_sequencer.sv
/*
 Data-flash command sequencer: indexed command object, launch by flag
 clear, checks, program and sector-erase via an external array port,
 verify flags, interrupts, stop hold-off and security load at reset.
 Assumes the array port answers each request with one-cycle MEM_DONE and
 that mode, protection and ECC fault inputs are synchronous to CLK.
*/
`timescale 1ns/100ps
`include "dfs_params.svh"
// Contract
// - Program: code 11, index 0/1 address
// - Words one to four from index 2-5
// - Program only if unprotected, else violation
// - Program index below 2 or above 5 errors
// - Invalid or odd address gives access error
// - Program run past block end errors
// - Verify after program, then set completion
// - Verify sets any-error and uncorrectable flags
// - Erase: code 12, index 1, valid even address in block
// - Erase whole sector, verify, then complete
// - Erase index other than 1 errors
// - Protected sector: violation, no erase
// - Command not allowed in mode errors
// - Command irq is flag and enable
// - Error irq from ECC flags and enables
// - Wait mode changes nothing
// - Stop waits for running command end
// - Security loaded from config byte at reset
// - New security byte needs next reset
// - Flag clear in reset; writes ignored
// - Reset aborts running command
module dfs_sequencer (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [2:0] COMMAND_INDEX_IN,
  input wire logic INDEX_WR,
  input wire logic [15:0] DATA_IN,
  input wire logic DATA_WR,
  input wire logic LAUNCH,
  input wire logic CLEAR_ERRORS,
  input wire logic COMMAND_COMPLETE_IRQ_ENABLE,
  input wire logic DOUBLE_FAULT_IRQ_ENABLE,
  input wire logic SINGLE_FAULT_IRQ_ENABLE,
  input wire logic DOUBLE_FAULT_SET,
  input wire logic SINGLE_FAULT_SET,
  input wire logic FAULT_CLEAR,
  input wire logic CMD_ALLOWED,
  input wire logic PROTECTED,
  input wire logic STOP_REQ,
  input wire logic WAIT_MODE,
  input wire logic [7:0] CONFIG_SEC_BYTE,
  input wire logic CONFIG_SEC_VALID,
  input wire logic MEM_DONE,
  input wire logic MEM_ERR,
  input wire logic MEM_UNCORR,
  output logic [2:0] COMMAND_INDEX,
  output logic COMMAND_COMPLETE_FLAG,
  output dfs_pkg::dfs_err_s ERR_FLAGS,
  output logic DOUBLE_FAULT_FLAG,
  output logic SINGLE_FAULT_FLAG,
  output logic [7:0] SECURITY_REG,
  output logic STOP_ACK,
  output dfs_pkg::dfs_mem_s MEM_REQ,
  output logic CMD_IRQ,
  output logic ERR_IRQ
);
  dfs_pkg::dfs_state_e st_q, st_d;
  logic [15:0] obj_q [0:5];
  logic [15:0] obj_d [0:5];
  logic [2:0] idx_q, idx_d, last_q, last_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] tmr_q, tmr_d;
  logic command_complete_flag_q, command_complete_flag_d, stop_q, stop_d, sec_ld_q, sec_ld_d;
  logic [7:0] sec_q, sec_d;
  dfs_pkg::dfs_err_s err_q, err_d;
  dfs_pkg::dfs_mem_s mem_q, mem_d;
  logic df_q, df_d, sf_q, sf_d;
  logic [7:0] code;
  logic [22:0] addr;
  logic prog, erase, bad_idx, bad_addr, past_end;

  always_comb begin
    code = obj_q[`DFS_IDX_CMD][15:8];
    addr = {obj_q[`DFS_IDX_CMD][6:0], obj_q[`DFS_IDX_ADDR]};
    prog = code == `DFS_CMD_PROGRAM;
    erase = code == `DFS_CMD_ERASE;
    bad_addr = (addr[22:16] != `DFS_BLK_HI) || addr[0]
      || (addr[15:0] > `DFS_BLK_LAST);
    // Last word address = start + 2*(count-1) must stay in block
    past_end = ({1'b0, addr[15:0]} + {13'h0, last_q - `DFS_IDX_WORD0, 1'b0})
      > {1'b0, `DFS_BLK_LAST};
    if (prog) begin
      bad_idx = (last_q < `DFS_IDX_WORD0) || (last_q > `DFS_IDX_WORD3);
    end else begin
      bad_idx = last_q != `DFS_IDX_ADDR;
    end
  end

  // One entry per command index 0 to 5; written only while idle
  for (genvar g = 0; g < 6; g++) begin : g_obj
    logic wr_en;
    always_comb begin
      wr_en = DATA_WR && (st_q == dfs_pkg::DFS_IDLE) && (idx_q == 3'(g));
      obj_d[g] = wr_en ? DATA_IN : obj_q[g];
    end

    always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
        obj_q[g] <= 16'h0000;
      end else begin
        obj_q[g] <= obj_d[g];
      end
    end
  end

  // Fault set wins over a clear in the same cycle
  always_comb begin
    df_d = DOUBLE_FAULT_SET | (df_q & ~FAULT_CLEAR);
    sf_d = SINGLE_FAULT_SET | (sf_q & ~FAULT_CLEAR);
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      df_q <= 1'b0;
      sf_q <= 1'b0;
    end else begin
      df_q <= df_d;
      sf_q <= sf_d;
    end
  end

  // Ack only once no command runs
  always_comb begin
    stop_d = STOP_REQ & command_complete_flag_q;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= stop_d;
    end
  end

  // Sampled once per reset; later programming waits for reset
  always_comb begin
    sec_d = sec_q;
    sec_ld_d = sec_ld_q;
    if (st_q == dfs_pkg::DFS_RST_SEQ && CONFIG_SEC_VALID && !sec_ld_q) begin
      sec_d = CONFIG_SEC_BYTE;
      sec_ld_d = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sec_q <= `DFS_SEC_DEFAULT;
      sec_ld_q <= 1'b0;
    end else begin
      sec_q <= sec_d;
      sec_ld_q <= sec_ld_d;
    end
  end

  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    last_d = last_q;
    cnt_d = cnt_q;
    tmr_d = tmr_q;
    command_complete_flag_d = command_complete_flag_q;
    err_d = err_q;
    mem_d = mem_q;
    mem_d.req = 1'b0;
    if (CLEAR_ERRORS && command_complete_flag_q) begin
      err_d.access_error_flag = 1'b0;
      err_d.protection_violation_flag = 1'b0;
    end
    // WAIT_MODE deliberately unused: operation is identical in wait
    unique case (st_q)
      dfs_pkg::DFS_RST_SEQ: begin
        tmr_d = tmr_q + 8'h01;
        if (tmr_q == `DFS_RESET_SEQ_CYC) begin
          command_complete_flag_d = 1'b1;
          st_d = dfs_pkg::DFS_IDLE;
        end
      end
      dfs_pkg::DFS_IDLE: begin
        // Object writes only while complete flag set
        if (INDEX_WR) begin
          idx_d = COMMAND_INDEX_IN;
          last_d = COMMAND_INDEX_IN;
        end
        if (LAUNCH && !STOP_REQ) begin
          command_complete_flag_d = 1'b0;
          err_d = '0;
          st_d = dfs_pkg::DFS_CHECK;
        end
      end
      dfs_pkg::DFS_CHECK: begin
        cnt_d = 3'h0;
        tmr_d = 8'h00;
        if (!(prog || erase) || !CMD_ALLOWED || bad_idx || bad_addr
            || (prog && past_end)) begin
          err_d.access_error_flag = 1'b1;
          command_complete_flag_d = 1'b1;
          st_d = dfs_pkg::DFS_IDLE;
        end else if (PROTECTED) begin
          err_d.protection_violation_flag = 1'b1;
          command_complete_flag_d = 1'b1;
          st_d = dfs_pkg::DFS_IDLE;
        end else begin
          st_d = dfs_pkg::DFS_WORK;
          mem_d.req = 1'b1;
          mem_d.erase = erase;
          mem_d.data = obj_q[`DFS_IDX_WORD0];
          if (erase) begin
            // Erase targets the sector base, address bits below cleared
            mem_d.addr = {addr[22:`DFS_SECT_BITS],
              `DFS_SECT_BITS'h0};
          end else begin
            mem_d.addr = addr;
          end
        end
      end
      dfs_pkg::DFS_WORK: begin
        if (MEM_DONE) begin
          if (!mem_q.erase && cnt_q + 3'h1 < last_q - 3'h1) begin
            cnt_d = cnt_q + 3'h1;
            mem_d.req = 1'b1;
            mem_d.addr = mem_q.addr + 23'h2;
            mem_d.data = obj_q[3'(`DFS_IDX_WORD0 + cnt_q + 3'h1)];
          end else begin
            st_d = dfs_pkg::DFS_VERIFY;
          end
        end
      end
      dfs_pkg::DFS_VERIFY: begin
        // Verify window; array reports error classes during it
        tmr_d = tmr_q + 8'h01;
        if (MEM_ERR) begin
          err_d.verify_any_error_flag = 1'b1;
        end
        if (MEM_UNCORR) begin
          err_d.verify_uncorrectable_flag = 1'b1;
        end
        if (tmr_q == (mem_q.erase ? `DFS_ERASE_CYC : `DFS_PROG_CYC)) begin
          command_complete_flag_d = 1'b1;
          st_d = dfs_pkg::DFS_IDLE;
        end
      end
      default: st_d = dfs_pkg::DFS_IDLE;
    endcase
  end

  // Async reset aborts any command; array content then undefined
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_q <= dfs_pkg::DFS_RST_SEQ;
      idx_q <= 3'h0;
      last_q <= 3'h0;
      cnt_q <= 3'h0;
      tmr_q <= 8'h00;
      command_complete_flag_q <= 1'b0;
      err_q <= '0;
      mem_q <= '0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      last_q <= last_d;
      cnt_q <= cnt_d;
      tmr_q <= tmr_d;
      command_complete_flag_q <= command_complete_flag_d;
      err_q <= err_d;
      mem_q <= mem_d;
    end
  end

  dfs_irq u_irq (
    .clk(CLK),
    .reset(RESET),
    .command_complete_flag(command_complete_flag_q),
    .command_complete_irq_enable(COMMAND_COMPLETE_IRQ_ENABLE),
    .double_fault_flag(df_q),
    .double_fault_irq_enable(DOUBLE_FAULT_IRQ_ENABLE),
    .single_fault_flag(sf_q),
    .single_fault_irq_enable(SINGLE_FAULT_IRQ_ENABLE),
    .cmd_irq(CMD_IRQ),
    .err_irq(ERR_IRQ)
  );

  always_comb begin
    COMMAND_INDEX = idx_q;
    COMMAND_COMPLETE_FLAG = command_complete_flag_q;
    ERR_FLAGS = err_q;
    DOUBLE_FAULT_FLAG = df_q;
    SINGLE_FAULT_FLAG = sf_q;
    SECURITY_REG = sec_q;
    STOP_ACK = stop_q;
    MEM_REQ = mem_q;
  end
endmodule : dfs_sequencer

// ### testbench/dfs_mem_model.sv
/*
 Array port model: one-cycle done per request, fast or slow.
 Assumes requests are registered on clk; verify faults are commanded.
*/
`timescale 1ns/100ps
module dfs_mem_model (
  input wire logic clk,
  input wire logic reset,
  input dfs_pkg::dfs_mem_s req,
  input wire logic slow,
  input wire logic [1:0] bad,
  output logic done,
  output logic err,
  output logic uncorr
);
  logic [2:0] cnt_q;
  assign err = bad[1];
  assign uncorr = bad[0];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 3'h0;
      done <= 1'h0;
    end else begin
      done <= cnt_q == 3'h1;
      if (req.req) cnt_q <= slow ? 3'h5 : 3'h1;
      else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
    end
  end
endmodule : dfs_mem_model

// ### testbench/dfs_sequencer_asserts.sv
/*
 Port checker of the sequencer.
 Assumes one clock; bound into every sequencer instance.
*/
`timescale 1ns/100ps
module dfs_sequencer_asserts (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic LAUNCH,
  input wire logic INDEX_WR,
  input wire logic STOP_REQ,
  input wire logic COMMAND_COMPLETE_IRQ_ENABLE,
  input wire logic DOUBLE_FAULT_IRQ_ENABLE,
  input wire logic SINGLE_FAULT_IRQ_ENABLE,
  input wire logic MEM_DONE,
  input wire logic [2:0] COMMAND_INDEX,
  input wire logic COMMAND_COMPLETE_FLAG,
  input dfs_pkg::dfs_err_s ERR_FLAGS,
  input wire logic DOUBLE_FAULT_FLAG,
  input wire logic SINGLE_FAULT_FLAG,
  input wire logic [7:0] SECURITY_REG,
  input wire logic STOP_ACK,
  input dfs_pkg::dfs_mem_s MEM_REQ,
  input wire logic CMD_IRQ,
  input wire logic ERR_IRQ
);
  logic f;
  assign f = COMMAND_COMPLETE_FLAG;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_cmd_irq;
    CMD_IRQ == $past(f && COMMAND_COMPLETE_IRQ_ENABLE);
  endproperty
  a_cmd_irq: assert property (p_cmd_irq) else $error("cmd irq");
  property p_err_irq;
    ERR_IRQ == $past(DOUBLE_FAULT_FLAG && DOUBLE_FAULT_IRQ_ENABLE
      || SINGLE_FAULT_FLAG && SINGLE_FAULT_IRQ_ENABLE);
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("err irq");
  property p_launch;
    LAUNCH && f && !STOP_REQ |=> !f;
  endproperty
  a_launch: assert property (p_launch) else $error("launch");
  property p_idx_hold;
    !f && INDEX_WR |=> $stable(COMMAND_INDEX);
  endproperty
  a_idx_hold: assert property (p_idx_hold) else $error("index");
  property p_stop;
    STOP_REQ && !f |=> !STOP_ACK;
  endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_busy_req;
    MEM_REQ.req |-> !f;
  endproperty
  a_busy_req: assert property (p_busy_req) else $error("req");
  property p_err_noreq;
    ERR_FLAGS.access_error_flag || ERR_FLAGS.protection_violation_flag
      |-> !MEM_REQ.req;
  endproperty
  a_err_noreq: assert property (p_err_noreq) else $error("no req");
  property p_sec;
    f |=> $stable(SECURITY_REG);
  endproperty
  a_sec: assert property (p_sec) else $error("security");
  property p_erase_end;
    MEM_DONE && MEM_REQ.erase && !f |-> ##[60:70] $rose(f);
  endproperty
  a_erase_end: assert property (p_erase_end) else $error("erase");
  c_erase: cover property (MEM_DONE && MEM_REQ.erase);
  c_verify: cover property (f && ERR_FLAGS.verify_any_error_flag);
  c_stop: cover property (STOP_REQ && STOP_ACK);
endmodule : dfs_sequencer_asserts
bind dfs_sequencer dfs_sequencer_asserts dfs_sequencer_asserts_inst (.*);

// ### testbench/tb_dfs_sequencer.sv
/*
 Bench of the sequencer: host side driven here, array port by the model.
 Assumes the design package and the checker are compiled first.
*/
`timescale 1ns/100ps
module tb_dfs_sequencer;
  logic CLK = 1'h0, RESET = 1'h1, INDEX_WR = 1'h0, DATA_WR = 1'h0;
  logic LAUNCH = 1'h0, CLEAR_ERRORS = 1'h0, FAULT_CLEAR = 1'h0;
  logic COMMAND_COMPLETE_IRQ_ENABLE = 1'h0, STOP_REQ = 1'h0;
  logic DOUBLE_FAULT_IRQ_ENABLE = 1'h0, SINGLE_FAULT_IRQ_ENABLE = 1'h0;
  logic DOUBLE_FAULT_SET = 1'h0, SINGLE_FAULT_SET = 1'h0, slow = 1'h0;
  logic CMD_ALLOWED = 1'h1, PROTECTED = 1'h0, WAIT_MODE = 1'h0;
  logic CONFIG_SEC_VALID = 1'h1, fp = 1'h0;
  logic [2:0] COMMAND_INDEX_IN = 3'h0, COMMAND_INDEX, li;
  logic [15:0] DATA_IN = 16'h0;
  logic [7:0] CONFIG_SEC_BYTE = 8'ha5, SECURITY_REG;
  logic [1:0] bad = 2'h0;
  logic MEM_DONE, MEM_ERR, MEM_UNCORR, COMMAND_COMPLETE_FLAG, STOP_ACK;
  logic DOUBLE_FAULT_FLAG, SINGLE_FAULT_FLAG, CMD_IRQ, ERR_IRQ;
  dfs_pkg::dfs_err_s ERR_FLAGS;
  dfs_pkg::dfs_mem_s MEM_REQ;
  logic [7:0] q[$];
  logic [39:0] mq[$], ms;
  int fails = 0, samples_checked = 0, cyc = 0, n = 0;
  dfs_sequencer dfs_sequencer_inst (.*);
  dfs_mem_model dfs_mem_model_inst (.clk(CLK), .reset(RESET),
    .req(MEM_REQ), .slow(slow), .bad(bad), .done(MEM_DONE),
    .err(MEM_ERR), .uncorr(MEM_UNCORR));
  initial begin
    forever #50 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  // Result seen at flag rise: array requests (program words and erase) counted, error flags
  always @(negedge CLK) begin
    ms = {MEM_REQ.erase, MEM_REQ.addr, MEM_REQ.erase ? 16'h0 : MEM_REQ.data};
    if (RESET) n = 0;
    else if (MEM_REQ.req) n++;
    if (!RESET && MEM_REQ.req && mq.size() > 0)
      chk("mem_req", ms, mq.pop_front());
    if (COMMAND_COMPLETE_FLAG && !fp) begin
      if (q.size() > 0)
        chk("result", {n[3:0], ERR_FLAGS}, q.pop_front());
      n = 0;
    end
    fp = COMMAND_COMPLETE_FLAG;
  end
  task automatic chk(string nm, logic [39:0] seen, logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic idx(logic [2:0] i);
    @(negedge CLK);
    COMMAND_INDEX_IN = i;
    INDEX_WR = 1'h1;
    @(negedge CLK);
    INDEX_WR = 1'h0;
  endtask : idx
  task automatic wr(logic [2:0] i, logic [15:0] d);
    idx(i);
    DATA_IN = d;
    DATA_WR = 1'h1;
    @(negedge CLK);
    DATA_WR = 1'h0;
  endtask : wr
  task automatic go();
    @(negedge CLK);
    LAUNCH = 1'h1;
    @(negedge CLK);
    LAUNCH = 1'h0;
  endtask : go
  task automatic wflag();
    repeat (400) if (COMMAND_COMPLETE_FLAG !== 1'h1) @(negedge CLK);
  endtask : wflag
  task automatic run(logic [7:0] c, logic [22:0] a, logic [2:0] l,
      logic [3:0] en, logic [3:0] ee);
    logic [15:0] d;
    wr(3'h0, {c, 1'h0, a[22:16]});
    wr(3'h1, a[15:0]);
    // Fresh addresses only, never reprogrammed
    for (int i = 2; i <= l && i < 6; i++) begin
      d = 16'($urandom);
      wr(3'(i), d);
      if (en != 4'h0 && c == 8'h11)
        mq.push_back({1'h0, a + 23'(2 * (i - 2)), d});
    end
    if (en != 4'h0 && c == 8'h12)
      mq.push_back({1'h1, a[22:8], 8'h00, 16'h0});
    idx(l);
    q.push_back({en, ee});
    go();
    wflag();
    $display("done %h %h", c, a);
  endtask : run
  task automatic fault(logic [1:0] s, logic [1:0] e, logic x);
    {DOUBLE_FAULT_IRQ_ENABLE, SINGLE_FAULT_IRQ_ENABLE} = e;
    {DOUBLE_FAULT_SET, SINGLE_FAULT_SET} = s;
    @(negedge CLK);
    {DOUBLE_FAULT_SET, SINGLE_FAULT_SET} = 2'h0;
    chk("fault_flag", {DOUBLE_FAULT_FLAG, SINGLE_FAULT_FLAG}, s);
    repeat (2) @(negedge CLK);
    chk("err_irq", ERR_IRQ, x);
    FAULT_CLEAR = 1'h1;
    @(negedge CLK);
    FAULT_CLEAR = 1'h0;
  endtask : fault
  task automatic tally_and_finish();
    $display("checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(32'hc6ac));
    repeat (20) @(negedge CLK);
    RESET = 1'h0;
    wflag();
    chk("sec", SECURITY_REG, 8'ha5);
    run(8'h11, 23'h100100, 3'h5, 4'h4, 4'h0);
    run(8'h11, 23'h100108, 3'h2, 4'h1, 4'h0);
    run(8'h11, 23'h10010a, 3'h1, 4'h0, 4'h8);
    run(8'h11, 23'h10010a, 3'h6, 4'h0, 4'h8);
    run(8'h11, 23'h10010b, 3'h2, 4'h0, 4'h8);
    run(8'h11, 23'h11010a, 3'h2, 4'h0, 4'h8);
    run(8'h11, 23'h101ffe, 3'h3, 4'h0, 4'h8);
    run(8'h11, 23'h101ffe, 3'h2, 4'h1, 4'h0);
    run(8'h12, 23'h100123, 3'h1, 4'h0, 4'h8);
    run(8'h12, 23'h102000, 3'h1, 4'h0, 4'h8);
    run(8'h12, 23'h100122, 3'h2, 4'h0, 4'h8);
    run(8'h12, 23'h100122, 3'h1, 4'h1, 4'h0);
    PROTECTED = 1'h1;
    run(8'h11, 23'h100110, 3'h2, 4'h0, 4'h4);
    run(8'h12, 23'h100110, 3'h1, 4'h0, 4'h4);
    PROTECTED = 1'h0;
    CMD_ALLOWED = 1'h0;
    run(8'h12, 23'h100200, 3'h1, 4'h0, 4'h8);
    CMD_ALLOWED = 1'h1;
    @(negedge CLK);
    CLEAR_ERRORS = 1'h1;
    @(negedge CLK);
    CLEAR_ERRORS = 1'h0;
    chk("clear", ERR_FLAGS, 8'h0);
    slow = 1'h1;
    bad = 2'h3;
    run(8'h11, 23'h100200, 3'h3, 4'h2, 4'h3);
    bad = 2'h2;
    run(8'h12, 23'h100300, 3'h1, 4'h1, 4'h2);
    bad = 2'h0;
    for (int k = 0; k < 4; k++) begin
      li = 3'h2 + 3'($urandom % 4);
      WAIT_MODE = 1'($urandom);
      slow = 1'($urandom);
      run(8'h11, {11'h100, 11'($urandom), 1'h0}, li, {1'h0, li - 3'h1},
        4'h0);
    end
    fork
      run(8'h12, 23'h100400, 3'h1, 4'h1, 4'h0);
      begin
        repeat (14) @(negedge CLK);
        STOP_REQ = 1'h1;
        repeat (4) @(negedge CLK);
        chk("stop_ack", STOP_ACK, 8'h0);
      end
    join
    @(negedge CLK);
    chk("stop_ack", STOP_ACK, 8'h1);
    go();
    chk("stop_hold", COMMAND_COMPLETE_FLAG, 8'h1);
    STOP_REQ = 1'h0;
    COMMAND_COMPLETE_IRQ_ENABLE = 1'h1;
    repeat (2) @(negedge CLK);
    chk("cmd_irq", CMD_IRQ, 8'h1);
    fault(2'h1, 2'h0, 1'h0);
    fault(2'h1, 2'h1, 1'h1);
    fault(2'h2, 2'h2, 1'h1);
    fault(2'h2, 2'h1, 1'h0);
    {DOUBLE_FAULT_SET, FAULT_CLEAR} = 2'h3;
    @(negedge CLK);
    {DOUBLE_FAULT_SET, FAULT_CLEAR} = 2'h0;
    chk("set_wins", DOUBLE_FAULT_FLAG, 8'h1);
    // Reset lands mid-program; the word content is then undefined
    CONFIG_SEC_BYTE = 8'h3c;
    wr(3'h0, 16'h1110);
    wr(3'h1, 16'h0500);
    wr(3'h2, 16'h1234);
    go();
    repeat (6) @(negedge CLK);
    chk("sec", SECURITY_REG, 8'ha5);
    RESET = 1'h1;
    @(negedge CLK);
    RESET = 1'h0;
    idx(3'h5);
    wflag();
    chk("index", COMMAND_INDEX, 8'h0);
    chk("abort", ERR_FLAGS, 8'h0);
    chk("sec", SECURITY_REG, 8'h3c);
    chk("queue", 8'(q.size() + mq.size()), 8'h0);
    tally_and_finish();
  end
endmodule : tb_dfs_sequencer
